//--- code_word_defines.svh
`ifndef CODE_WORD_DEFINES_SVH
`define CODE_WORD_DEFINES_SVH

// clock and timing figures
`define CLK_MHZ 125
`define TE_BASE_US 100
`define SHUTOFF_S 25
`define LED_BLINK_HZ 5

// element multipliers for the rate settings
`define TE_MULT_400 20'h0_0004
`define TE_MULT_200 20'h0_0002

// word layout, in elements and bits
`define PRE_LEN 7'h17
`define HDR_LEN 7'h0A
`define GUARD_LEN 7'h27
`define WORD_BITS 7'h42
`define SYNC_BITS 7'h52
`define LAST_PHASE 2'h2

// apb byte offsets
`define OFS_CONFIG 12'h000
`define OFS_SYNC 12'h004
`define OFS_SERIAL 12'h008
`define OFS_SEED 12'h00C
`define OFS_CTRL 12'h010
`define OFS_STATUS 12'h014
`define OFS_BLOCK 12'h018

// config and serial field positions
`define CFG_WRAP_FIRST 10
`define CFG_WRAP_SECOND 11
`define CFG_TRIP 12
`define CFG_RATE_LO 13
`define CFG_RATE_HI 14
`define SER_SHUTOFF 31

// reset values, sync limit and function codes
`define CONFIG_RST 16'h0000
`define SYNC_RST 16'h0000
`define WORD32_RST 32'h0000_0000
`define SYNC_MAX 16'hFFFF
`define FUNC_SEED 4'hF
`define FUNC_NONE 4'h0

`endif

//--- code_word_pkg.sv
package code_word_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_pre = 3'h1,
      st_hdr = 3'h3,
      st_data = 3'h2,
      st_guard = 3'h6,
      st_timeout = 3'h7,
      st_sync_load = 3'h4,
      st_sync_data = 3'h5
   } tx_state_t;
endpackage : code_word_pkg

//--- element_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "code_word_defines.svh"
module element_tick #(
   parameter logic [19:0] TE100_CYCLES = 20'(`TE_BASE_US * `CLK_MHZ)
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // control
   input wire logic restart,
   input wire logic [1:0] rate_sel,
   // one pulse per pulse element
   output logic tick
);
   logic [19:0] cnt;
   logic [19:0] limit;

   function automatic logic [19:0] element_len(input logic [1:0] sel);
      if (sel == 2'h0) begin
         return 20'(TE100_CYCLES * `TE_MULT_400);
      end else if (sel == 2'h1) begin
         return 20'(TE100_CYCLES * `TE_MULT_200);
      end else begin
         return TE100_CYCLES;
      end
   endfunction : element_len

   assign limit = element_len(rate_sel);

   always_ff @(posedge clk_sys) begin
      if (reset || restart) begin
         cnt <= 20'h0_0000;
         tick <= 1'b0;
      end else if (cnt >= limit - 20'h0_0001) begin
         cnt <= 20'h0_0000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 20'h0_0001;
         tick <= 1'b0;
      end
   end
endmodule : element_tick
`default_nettype wire

//--- code_word_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "code_word_defines.svh"
// Operation
// - rate bits set element 400/200/100 us
// - rate bits blank none, half or three quarters
// - trip bit picks 5-6 V or 3 V threshold
// - preamble, header, 32 hop, 34 fixed, guard
// - button press produces 66-bit code word
// - hop block is buttons, discrimination, sync
// - fixed part is status, buttons, serial
// - armed fall of buttons 2/3 enters sync
// - sync mode bits clocked externally, 16 extra
// - sync mode code is buttons 0/1 at entry
// - released button still completes word
// - held button repeats words back to back
// - extra button aborts and restarts
// - indicator low during tx, blinks if low supply
// - repeat bit zero first, then one
// - every word carries low supply bit
// - enabled shutoff stops after 25 s hold
// - all four buttons send seed instead
// - sync counter increments per transmission
// - shutoff enable is serial bit 31
// - wraps clear first then second flag
module code_word_tx
   import code_word_pkg::*;
#(
   parameter logic [19:0] TE100_CYCLES = 20'(`TE_BASE_US * `CLK_MHZ),
   parameter logic [31:0] SHUTOFF_CYCLES =
      32'(64'(`SHUTOFF_S) * 64'(`CLK_MHZ) * 64'd1000000),
   parameter logic [31:0] LED_HALF_CYCLES =
      32'((`CLK_MHZ * 1000000) / (2 * `LED_BLINK_HZ))
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // buttons and supply comparators
   input wire logic button_in_0,
   input wire logic button_in_1,
   input wire logic button_in_2,
   input wire logic button_in_3,
   input wire logic supply_below_3v,
   input wire logic supply_below_5v,
   // cipher outside this block
   output logic [31:0] plain_block,
   input wire logic [31:0] cipher_in,
   // serial data and indicator
   output logic data_out,
   output logic indicator_out_n
);
   tx_state_t state;
   logic [15:0] config_word;
   logic [15:0] sync;
   logic [31:0] serial;
   logic [31:0] seed;
   logic sync_arm;
   logic [3:0] btn_lat;
   logic repeat_flag;
   logic low_supply_flag;
   logic sync_mode;
   logic [81:0] shreg;
   logic [6:0] elem_cnt;
   logic [6:0] bit_cnt;
   logic [1:0] phase;
   logic [1:0] slot;
   logic [31:0] hold_cnt;
   logic [31:0] led_cnt;
   logic blink;
   logic ext_clk_d;
   logic tick;

   logic [3:0] btn_now;
   logic [3:0] btn_sel;
   logic [1:0] rate_sel;
   logic ext_clk;
   logic ext_fall;
   logic ext_rise;
   logic tx_active;
   logic new_press;
   logic start_tx;
   logic abort;
   logic sync_enter;
   logic word_end;
   logic next_word;
   logic timed_out;
   logic begin_tx;
   logic load_word;
   logic sending;
   logic supply_low;
   logic wr_en;
   logic rd_setup;

   assign btn_now = {button_in_3, button_in_2, button_in_1, button_in_0};
   assign rate_sel = {config_word[`CFG_RATE_HI], config_word[`CFG_RATE_LO]};
   assign ext_clk = button_in_2 | button_in_3;
   assign ext_fall = ext_clk_d & ~ext_clk;
   assign ext_rise = ~ext_clk_d & ext_clk;
   assign tx_active = (state == st_pre) || (state == st_hdr) ||
                      (state == st_data) || (state == st_guard);
   assign new_press = (btn_now & ~btn_lat) != `FUNC_NONE;
   assign start_tx = (state == st_idle) && !sync_arm &&
                     (btn_now != `FUNC_NONE);
   // a timed-out hold must not be revived by pressing one more button
   assign abort = tx_active && new_press && !timed_out;
   assign sync_enter = (state == st_idle) && sync_arm && ext_fall &&
                       (button_in_0 | button_in_1);
   assign word_end = (state == st_guard) && tick &&
                     (elem_cnt == `GUARD_LEN - 7'h01);
   assign timed_out = serial[`SER_SHUTOFF] &&
                      (hold_cnt >= SHUTOFF_CYCLES);
   assign next_word = word_end && (btn_now != `FUNC_NONE) &&
                      !timed_out;
   assign begin_tx = start_tx || abort || sync_enter;
   assign load_word = begin_tx || next_word;
   assign btn_sel = sync_enter ? {2'h0, button_in_1, button_in_0} :
                    btn_now;
   assign supply_low = config_word[`CFG_TRIP] ? supply_below_5v :
                       supply_below_3v;
   always_comb begin
      case (rate_sel)
         2'h0: sending = 1'b1;
         2'h1, 2'h2: sending = (slot[0] == 1'b0);
         default: sending = (slot == 2'h0);
      endcase
   end
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   element_tick #(
      .TE100_CYCLES(TE100_CYCLES)
   ) u_tick (
      .clk_sys(clk_sys),
      .reset(reset),
      .restart(load_word),
      .rate_sel(rate_sel),
      .tick(tick)
   );

   // software registers; hardware flag clearing wins over a write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         config_word <= `CONFIG_RST;
         sync <= `SYNC_RST;
         serial <= `WORD32_RST;
         seed <= `WORD32_RST;
         sync_arm <= 1'b0;
      end else begin
         if (wr_en && paddr == `OFS_CONFIG) begin
            config_word <= {1'b0, pwdata[14:0]};
         end else if (wr_en && paddr == `OFS_SERIAL) begin
            serial <= pwdata;
         end else if (wr_en && paddr == `OFS_SEED) begin
            seed <= pwdata;
         end else if (wr_en && paddr == `OFS_CTRL) begin
            sync_arm <= pwdata[0];
         end else if (wr_en && paddr == `OFS_SYNC && !begin_tx) begin
            sync <= pwdata[15:0];
         end
         if (begin_tx) begin
            sync <= sync + 16'h0001;
            if (sync == `SYNC_MAX) begin
               if (config_word[`CFG_WRAP_FIRST]) begin
                  config_word[`CFG_WRAP_FIRST] <= 1'b0;
               end else begin
                  config_word[`CFG_WRAP_SECOND] <= 1'b0;
               end
            end
         end
         if (sync_enter) begin
            sync_arm <= 1'b0;
         end
      end
   end

   // apb answer prepared in the setup cycle, zero wait states
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prdata <= `WORD32_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (rd_setup) begin
            pslverr <= 1'b0;
            if (paddr == `OFS_CONFIG) begin
               prdata <= {16'h0000, config_word};
            end else if (paddr == `OFS_SYNC) begin
               prdata <= {16'h0000, sync};
            end else if (paddr == `OFS_SERIAL) begin
               prdata <= serial;
            end else if (paddr == `OFS_SEED) begin
               prdata <= seed;
            end else if (paddr == `OFS_CTRL) begin
               prdata <= {31'h0000_0000, sync_arm};
            end else if (paddr == `OFS_STATUS) begin
               prdata <= {25'h000_0000, timed_out, sync_mode,
                          repeat_flag, low_supply_flag, state};
            end else if (paddr == `OFS_BLOCK) begin
               prdata <= plain_block;
            end else begin
               prdata <= `WORD32_RST;
               pslverr <= 1'b1;
            end
         end
      end
   end

   // plaintext block handed to the cipher
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         plain_block <= `WORD32_RST;
      end else begin
         plain_block <= {btn_sel, config_word[`CFG_WRAP_SECOND],
                         config_word[`CFG_WRAP_FIRST], config_word[9:0],
                         sync};
      end
   end

   // word status and shift register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         btn_lat <= `FUNC_NONE;
         repeat_flag <= 1'b0;
         low_supply_flag <= 1'b0;
         shreg <= '0;
      end else if (load_word) begin
         btn_lat <= btn_sel;
         repeat_flag <= next_word && !begin_tx;
         low_supply_flag <= supply_low;
         shreg <= {16'h0000, next_word && !begin_tx, supply_low, btn_sel,
                   serial[27:0],
                   (btn_sel == `FUNC_SEED) ? seed : cipher_in};
      end else if ((state == st_data && tick && phase == `LAST_PHASE) ||
                   (state == st_sync_data && ext_rise)) begin
         shreg <= {1'b0, shreg[81:1]};
      end
   end

   // sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= st_idle;
         elem_cnt <= 7'h00;
         bit_cnt <= 7'h00;
         phase <= 2'h0;
         slot <= 2'h0;
         sync_mode <= 1'b0;
      end else if (begin_tx || next_word) begin
         elem_cnt <= 7'h00;
         bit_cnt <= 7'h00;
         phase <= 2'h0;
         slot <= begin_tx ? 2'h0 : slot + 2'h1;
         sync_mode <= sync_enter;
         state <= sync_enter ? st_sync_load : st_pre;
      end else if (tx_active && timed_out) begin
         state <= st_timeout;
      end else begin
         case (state)
            st_pre: begin
               if (tick) begin
                  elem_cnt <= elem_cnt + 7'h01;
                  if (elem_cnt == `PRE_LEN - 7'h01) begin
                     elem_cnt <= 7'h00;
                     state <= st_hdr;
                  end
               end
            end
            st_hdr: begin
               if (tick) begin
                  elem_cnt <= elem_cnt + 7'h01;
                  if (elem_cnt == `HDR_LEN - 7'h01) begin
                     elem_cnt <= 7'h00;
                     state <= st_data;
                  end
               end
            end
            st_data: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  if (phase == `LAST_PHASE) begin
                     phase <= 2'h0;
                     bit_cnt <= bit_cnt + 7'h01;
                     if (bit_cnt == `WORD_BITS - 7'h01) begin
                        state <= st_guard;
                     end
                  end
               end
            end
            st_guard: begin
               if (tick) begin
                  elem_cnt <= elem_cnt + 7'h01;
               end
               if (word_end) begin
                  state <= st_idle;
               end
            end
            st_timeout: begin
               if (btn_now == `FUNC_NONE) begin
                  state <= st_idle;
               end
            end
            st_sync_load: begin
               state <= st_sync_data;
            end
            st_sync_data: begin
               if (ext_rise) begin
                  bit_cnt <= bit_cnt + 7'h01;
                  if (bit_cnt == `SYNC_BITS - 7'h01) begin
                     state <= st_idle;
                     sync_mode <= 1'b0;
                  end
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // hold timer for auto shutoff
   always_ff @(posedge clk_sys) begin
      if (reset || btn_now == `FUNC_NONE) begin
         hold_cnt <= 32'h0000_0000;
      end else if (hold_cnt != 32'hFFFF_FFFF) begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
      end
   end

   // external clock history
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ext_clk_d <= 1'b0;
      end else begin
         ext_clk_d <= ext_clk;
      end
   end

   // serial output level
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_out <= 1'b0;
      end else if (state == st_sync_data) begin
         data_out <= shreg[0];
      end else if (!sending || !tx_active) begin
         data_out <= 1'b0;
      end else if (state == st_pre) begin
         data_out <= ~elem_cnt[0];
      end else if (state == st_data) begin
         data_out <= (phase == 2'h0) || (phase == 2'h1 && !shreg[0]);
      end else begin
         data_out <= 1'b0;
      end
   end

   // indicator, blinking when supply is low
   always_ff @(posedge clk_sys) begin
      if (reset || !tx_active) begin
         led_cnt <= 32'h0000_0000;
         blink <= 1'b0;
      end else if (led_cnt >= LED_HALF_CYCLES - 32'h0000_0001) begin
         led_cnt <= 32'h0000_0000;
         blink <= ~blink;
      end else begin
         led_cnt <= led_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         indicator_out_n <= 1'b1;
      end else begin
         indicator_out_n <= !tx_active ||
                            (low_supply_flag && blink);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   chk_standby_idle: assert property (
      state == st_idle && btn_now == `FUNC_NONE |=> state == st_idle)
      else $error("left standby with no button");
   chk_first_repeat: assert property (
      begin_tx |=> !repeat_flag && state inside {st_pre, st_sync_load})
      else $error("first word has repeat set");
   chk_later_repeat: assert property (
      next_word && !begin_tx |=> repeat_flag ##0 shreg[65])
      else $error("repeat word without repeat bit");
   chk_sync_step: assert property (
      begin_tx |=> sync == $past(sync) + 16'h0001)
      else $error("sync counter not incremented");
   chk_abort_word: assert property (
      abort && !timed_out |=> state == st_pre && elem_cnt == 7'h00)
      else $error("new button did not restart");
   chk_led_steady: assert property (
      tx_active && !low_supply_flag && !load_word ##1 tx_active
      |-> !indicator_out_n)
      else $error("indicator not low during transmission");
   chk_blank_slot: assert property (
      tx_active && !sending |=> !data_out)
      else $error("blanked slot drove output");
   chk_word_finish: assert property (
      state == st_data && btn_now == `FUNC_NONE && !timed_out
      |=> state inside {st_data, st_guard})
      else $error("released button cut word short");
   chk_seed_word: assert property (
      load_word && btn_sel == `FUNC_SEED |=> shreg[31:0] == $past(seed))
      else $error("seed not sent for function 15");
   chk_auto_shutoff: assert property (
      tx_active && timed_out |=> state == st_timeout)
      else $error("shutoff did not stop transmission");
   chk_wrap_flag: assert property (
      begin_tx && sync == `SYNC_MAX && config_word[`CFG_WRAP_FIRST]
      |=> !config_word[`CFG_WRAP_FIRST] && sync == `SYNC_RST)
      else $error("first wrap flag not cleared");
   chk_sync_capture: assert property (
      sync_enter |=> shreg[63:60] == {2'h0, $past(button_in_1),
                                      $past(button_in_0)})
      else $error("sync mode button code wrong");

   cov_new_tx: cover property (start_tx ##1 state == st_pre);
   cov_repeat: cover property (next_word ##1 repeat_flag);
   cov_abort: cover property (abort);
   cov_sync_mode: cover property (sync_enter ##1 state == st_sync_load);
endmodule : code_word_tx
`default_nettype wire

//--- code_word_rx.sv
`timescale 1ns/1ps
`default_nettype none
module code_word_rx (
   // clock
   input wire logic clk_sys,
   // line from the transmitter
   input wire logic data_out,
   input wire logic [7:0] te,
   // decoded words
   output logic [65:0] word,
   output int n_words,
   output int n_bad
);
   int t;
   // sample each element in its middle, starting at the first high
   initial begin
      word = '0;
      n_words = 0;
      n_bad = 0;
      forever begin
         do begin
            @(posedge clk_sys);
         end while (data_out !== 1'b1);
         t = int'(te);
         repeat (t / 2) @(posedge clk_sys);
         for (int k = 0; k < 33; k++) begin
            if (data_out !== (k < 23 && k % 2 == 0)) n_bad++;
            repeat (t) @(posedge clk_sys);
         end
         for (int i = 0; i < 66; i++) begin
            if (data_out !== 1'b1) n_bad++;
            repeat (t) @(posedge clk_sys);
            word[i] = ~data_out;
            repeat (t) @(posedge clk_sys);
            if (data_out !== 1'b0) n_bad++;
            repeat (t) @(posedge clk_sys);
         end
         // step 36 of the 39 guard elements before waiting for the next word
         repeat (36 * t) @(posedge clk_sys);
         n_words++;
      end
   end
endmodule : code_word_rx
`default_nettype wire

//--- test_hopping_code_word_transmitter.sv
`timescale 1ns/1ps
`default_nettype none
`include "code_word_defines.svh"
module test_hopping_code_word_transmitter;
   localparam logic [31:0] CIPH = 32'h5A3C_96E1;
   localparam logic [31:0] SER = 32'h0ABC_DE12;
   localparam logic [31:0] SEED = 32'h1357_9BDF;
   // sync clock half period, scaled with the shortened time base
   localparam int SYNC_HALF = 16;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, plain_block;
   logic [3:0] btn;
   logic sup3, sup5, data_out, indicator_out_n;
   logic [7:0] te;
   logic [65:0] word;
   int n_words, n_bad, err_count, n_compared, cyc;
   code_word_tx #(
      .TE100_CYCLES(20'h0_0004),
      .SHUTOFF_CYCLES(32'h0000_00C8),
      .LED_HALF_CYCLES(32'h0000_0008)
   ) dut_u (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .button_in_0(btn[0]),
      .button_in_1(btn[1]), .button_in_2(btn[2]), .button_in_3(btn[3]),
      .supply_below_3v(sup3), .supply_below_5v(sup5),
      .plain_block(plain_block), .cipher_in(CIPH), .data_out(data_out),
      .indicator_out_n(indicator_out_n)
   );
   code_word_rx rx_u (
      .clk_sys(clk_sys), .data_out(data_out), .te(te), .word(word),
      .n_words(n_words), .n_bad(n_bad)
   );
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         $display("wrong value at %0t: run too long", $time);
         final_report();
      end
   end
   task automatic check(input logic [81:0] g, input logic [81:0] e,
         input string m);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x,
         input string m);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, x, m);
   endtask : rd
   task automatic wait_idle();
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, `OFS_STATUS, 32'h0000_0000, r, e);
         n++;
      end while (r[2:0] !== 3'h0 && n < 3000);
      check(n < 3000, 1'b1, "no return to idle");
   endtask : wait_idle
   function automatic logic [7:0] te_of(input logic [15:0] c);
      return c[14] ? 8'h04 : (c[13] ? 8'h08 : 8'h10);
   endfunction : te_of
   task automatic test_regs();
      logic [31:0] r;
      logic e;
      repeat (50) @(posedge clk_sys);
      check(data_out, 1'b0, "standby line");
      rd(`OFS_STATUS, 32'h0000_0000, "standby state");
      rd(`OFS_CONFIG, 32'h0000_0000, "config reset");
      rd(`OFS_SYNC, 32'h0000_0000, "sync reset");
      wr(`OFS_SERIAL, SER);
      wr(`OFS_SEED, SEED);
      rd(`OFS_SERIAL, SER, "serial readback");
      apb(1'b0, 12'h040, 32'h0000_0000, r, e);
      check(e, 1'b1, "unmapped error");
      $display("test_regs done");
   endtask : test_regs
   task automatic test_word(input logic [15:0] cfg, input logic [15:0] sync0,
         input logic [3:0] b, input logic low);
      logic [15:0] ec;
      int w0, b0;
      ec = cfg;
      if (sync0 == 16'hFFFF && cfg[10]) ec[10] = 1'b0;
      else if (sync0 == 16'hFFFF) ec[11] = 1'b0;
      te = te_of(cfg);
      wr(`OFS_CONFIG, {16'h0000, cfg});
      wr(`OFS_SYNC, {16'h0000, sync0});
      w0 = n_words;
      b0 = n_bad;
      btn <= b;
      repeat (6) @(posedge clk_sys);
      check(plain_block[31:16], {b, ec[11:0]}, "plain block");
      check(indicator_out_n, 1'b0, "indicator on");
      if (low) begin
         repeat (8) @(posedge clk_sys);
         check(indicator_out_n, 1'b1, "indicator blink");
      end
      btn <= 4'h0;
      wait_idle();
      check(n_words - w0, 1, "one word");
      check(n_bad - b0, 0, "word shape");
      check(word, {1'b0, low, b, SER[27:0], (b == 4'hF) ? SEED : CIPH},
         "word content");
      rd(`OFS_SYNC, {16'h0000, sync0 + 16'h0001}, "sync count");
      rd(`OFS_CONFIG, {16'h0000, ec}, "wrap flags");
      $display("test_word done");
   endtask : test_word
   task automatic test_hold(input logic [15:0] cfg, input int slots,
         input int expw);
      int w0;
      te = te_of(cfg);
      wr(`OFS_CONFIG, {16'h0000, cfg});
      wr(`OFS_SYNC, 32'h0000_0000);
      w0 = n_words;
      btn <= 4'h4;
      repeat ((slots - 1) * 270 * int'(te) + 30) @(posedge clk_sys);
      btn <= 4'h0;
      wait_idle();
      check(n_words - w0, expw, "words sent");
      check(word[65], 1'b1, "repeat flag");
      rd(`OFS_SYNC, 32'h0000_0001, "one count a hold");
      $display("test_hold done");
   endtask : test_hold
   task automatic test_abort();
      te = 8'h10;
      wr(`OFS_CONFIG, 32'h0000_0000);
      wr(`OFS_SYNC, 32'h0000_0000);
      btn <= 4'h1;
      repeat (40) @(posedge clk_sys);
      btn <= 4'h3;
      repeat (4450) @(posedge clk_sys);
      btn <= 4'h0;
      wait_idle();
      check(word[63:60], 4'h3, "new buttons");
      rd(`OFS_SYNC, 32'h0000_0002, "restart count");
      $display("test_abort done");
   endtask : test_abort
   task automatic test_shutoff(input logic en);
      logic [31:0] r;
      logic e;
      te = 8'h04;
      wr(`OFS_CONFIG, 32'h0000_6000);
      wr(`OFS_SERIAL, {en, SER[30:0]});
      btn <= 4'h8;
      repeat (260) @(posedge clk_sys);
      apb(1'b0, `OFS_STATUS, 32'h0000_0000, r, e);
      check(r[2:0] == 3'h7, en, "timeout state");
      if (en) check(data_out, 1'b0, "line quiet");
      btn <= 4'h0;
      wait_idle();
      $display("test_shutoff done");
   endtask : test_shutoff
   task automatic test_sync();
      logic [81:0] ew;
      logic [31:0] r;
      logic e;
      ew = {16'h0000, 2'b00, 4'h2, SER[27:0], CIPH};
      sup3 <= 1'b0;
      wr(`OFS_CONFIG, 32'h0000_0000);
      wr(`OFS_CTRL, 32'h0000_0001);
      btn <= 4'h6;
      repeat (4) @(posedge clk_sys);
      btn <= 4'h2;
      repeat (2) @(posedge clk_sys);
      btn <= 4'h0;
      repeat (4) @(posedge clk_sys);
      apb(1'b0, `OFS_STATUS, 32'h0000_0000, r, e);
      check(r[5], 1'b1, "sync mode");
      for (int i = 0; i < 82; i++) begin
         check(data_out, ew[i], "sync bit");
         btn <= 4'h4;
         repeat (SYNC_HALF) @(posedge clk_sys);
         btn <= 4'h0;
         repeat (SYNC_HALF) @(posedge clk_sys);
      end
      wait_idle();
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rd(`OFS_SYNC, 32'h0000_0000, "sync after reset");
      $display("test_sync done");
   endtask : test_sync
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      btn = 4'h0;
      sup3 = 1'b0;
      sup5 = 1'b0;
      te = 8'h10;
      err_count = 0;
      n_compared = 0;
      cyc = 0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      test_regs();
      test_word(16'h0000, 16'h0010, 4'h1, 1'b0);
      test_word(16'h2C00, 16'hFFFF, 4'h2, 1'b0);
      sup3 <= 1'b1;
      test_word(16'h4800, 16'hFFFF, 4'hF, 1'b1);
      test_word(16'h7155, 16'h1234, 4'hC, 1'b0);
      test_hold(16'h0000, 2, 2);
      test_hold(16'h2000, 3, 2);
      test_hold(16'h4000, 3, 2);
      test_hold(16'h6000, 5, 2);
      test_abort();
      test_shutoff(1'b1);
      test_shutoff(1'b0);
      test_sync();
      final_report();
   end
endmodule : test_hopping_code_word_transmitter
`default_nettype wire
